/* rtl/smps_fault_startup_supervisor.sv */
// Fault qualification, latch-off, restart and soft-start supervisor with APB registers
`timescale 1ns/1ps
`default_nettype none
module smps_fault_startup_supervisor #(
    parameter int unsigned QUAL_COUNT = smps_supervisor_pkg::QUAL_CYCLES,
    parameter int unsigned SS_COUNT = smps_supervisor_pkg::SS_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparators from the analog front end (asynchronous)
    input wire logic vcc_above_high,
    input wire logic vcc_below_low,
    input wire logic vcc_below_latchoff,
    input wire logic vcc_below_reset,
    input wire logic peak_clamp,
    input wire logic cs_above_latch,
    input wire logic skip_request,
    input wire logic switch_on,
    // Control outputs
    output logic drive_enable,
    output logic startup_source_en,
    output logic low_power,
    output logic error_flag,
    output logic front_end_supply_switch,
    output logic [smps_supervisor_pkg::LEVEL_W-1:0] current_limit_level
);
    import smps_supervisor_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [CMP_N-1:0] cmp_raw;
    logic [CMP_N-1:0] meta_q;
    logic [CMP_N-1:0] sync_q;
    assign cmp_raw = {switch_on, skip_request, cs_above_latch, peak_clamp,
                      vcc_below_reset, vcc_below_latchoff, vcc_below_low, vcc_above_high};

    // Comparators switch at any time; two stages keep metastability out of the sequencer
    // two-stage sampling
    genvar gi;
    generate
        for (gi = 0; gi < CMP_N; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= cmp_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    wire vcc_high = sync_q[CMP_VCC_HIGH];
    wire vcc_low = sync_q[CMP_VCC_LOW];
    wire vcc_latchoff = sync_q[CMP_VCC_LATCHOFF];
    wire vcc_reset = sync_q[CMP_VCC_RESET];
    wire err_s = sync_q[CMP_CLAMP];
    wire cs_s = sync_q[CMP_CS_LATCH];
    wire skip_s = sync_q[CMP_SKIP];
    wire sw_on_s = sync_q[CMP_SWITCH_ON];

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    sup_state_e state_q, state_d;
    logic [QUAL_W-1:0] qual_cnt_q, qual_cnt_d;
    logic [SS_W-1:0] ss_pre_q, ss_pre_d;
    logic [LEVEL_W-1:0] ss_level_q, ss_level_d;
    logic div_q, div_d;
    logic err_prev_q;
    logic skip_prev_q;
    logic pfc_q, pfc_d;
    logic drive_q;
    logic inhibit_q;
    logic [31:0] prdata_q;

    localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_COUNT - 1);
    localparam logic [SS_W-1:0] SS_STEP_LAST = SS_W'((SS_COUNT / LEVEL_STEPS) - 1);

    // error flag is the clamp comparator, sampled
    assign error_flag = err_s;

    // sense comparator only counts while the switch is off
    wire cs_hit = cs_s && !sw_on_s;
    wire in_run = (state_q == ST_RUN);
    // timer counts while flag high in run
    wire qual_exp = in_run && err_s && (qual_cnt_q == QUAL_LAST);
    wire err_fall = err_prev_q && !err_s;
    wire skip_exit = skip_prev_q && !skip_s;
    wire restart = (state_q == ST_RECHARGE) && vcc_high && div_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        div_d = div_q;
        unique case (state_q)
            // charge until stop threshold, then drive
            ST_CHARGE: begin
                if (vcc_high) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (cs_hit) begin
                    state_d = ST_CSLATCH;
                end else if (vcc_low) begin
                    state_d = ST_LATCHOFF;
                end else if (qual_exp) begin
                    state_d = ST_FAULT;
                end
            end
            ST_FAULT: begin
                if (vcc_low) begin
                    state_d = ST_LATCHOFF;
                end
            end
            ST_LATCHOFF: begin
                if (vcc_latchoff) begin
                    state_d = ST_RECHARGE;
                end
            end
            ST_RECHARGE: begin
                if (vcc_high) begin
                    div_d = !div_q;
                    state_d = div_q ? ST_RUN : ST_FAULT;
                end
            end
            ST_CSLATCH: begin
                state_d = ST_CSLATCH;
            end
            default: begin
                state_d = ST_CHARGE;
            end
        endcase
        // Vcc below reset level starts over from power-up
        if (vcc_reset) begin
            state_d = ST_CHARGE;
            div_d = 1'b0;
        end
    end

    // any flag drop clears the timer
    assign qual_cnt_d = (in_run && err_s && !qual_exp) ? qual_cnt_q + 1'b1 : '0;

    // ------------------------------------------------------------
    // Soft-start ramp
    // ------------------------------------------------------------
    // ramp restarts on startup, restart and skip exit
    wire ss_start = (state_q == ST_CHARGE && state_d == ST_RUN) || restart
                    || (in_run && skip_exit);
    wire ss_tick = (ss_pre_q == SS_STEP_LAST);

    // Held at zero outside run so a restart never inherits a stale limit
    always_comb begin
        ss_pre_d = ss_tick ? '0 : ss_pre_q + 1'b1;
        ss_level_d = ss_level_q;
        if (ss_start) begin
            ss_pre_d = '0;
            ss_level_d = '0;
        end else if (!in_run) begin
            ss_level_d = '0;
        end else if (ss_tick && ss_level_q != LEVEL_MAX) begin
            ss_level_d = ss_level_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Front-end supply switch
    // ------------------------------------------------------------
    always_comb begin
        pfc_d = pfc_q;
        if (!in_run || qual_exp || cs_hit) begin
            pfc_d = 1'b0;
        // flag dropped in time: normal startup
        end else if (err_fall) begin
            pfc_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_CHARGE;
            div_q <= 1'b0;
            qual_cnt_q <= '0;
            ss_pre_q <= '0;
            ss_level_q <= '0;
            err_prev_q <= 1'b0;
            skip_prev_q <= 1'b0;
            pfc_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            state_q <= state_d;
            div_q <= div_d;
            qual_cnt_q <= qual_cnt_d;
            ss_pre_q <= ss_pre_d;
            ss_level_q <= ss_level_d;
            err_prev_q <= err_s;
            skip_prev_q <= skip_s;
            pfc_q <= pfc_d;
            // drive only in run, never after a sense trip
            drive_q <= (state_d == ST_RUN) && !cs_hit && !inhibit_q;
        end
    end

    assign drive_enable = drive_q;
    // switch also gated off by state
    assign front_end_supply_switch = pfc_q && (state_q != ST_CSLATCH);
    assign startup_source_en = (state_q == ST_CHARGE) || (state_q == ST_RECHARGE);
    assign low_power = (state_q == ST_LATCHOFF) || (state_q == ST_CSLATCH);
    assign current_limit_level = ss_level_q;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Zero wait states; read data captured in the setup cycle
    wire sel_ctrl = (paddr == CTRL_OFF);
    wire sel_status = (paddr == STATUS_OFF);
    wire mapped = sel_ctrl || sel_status;
    wire setup_rd = psel && !penable && !pwrite;
    wire access_wr = psel && penable && pwrite && sel_ctrl;
    wire [31:0] status_word = {24'h000000, (ss_level_q == LEVEL_MAX), skip_s, div_q,
                               pfc_q, err_s, state_q};
    wire [31:0] ctrl_word = {31'h00000000, inhibit_q};
    wire [31:0] rd_mux = sel_ctrl ? ctrl_word : (sel_status ? status_word : 32'h00000000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_q <= CTRL_INHIBIT_RST;
            prdata_q <= 32'h00000000;
        end else begin
            if (access_wr) begin
                inhibit_q <= pwdata[CTRL_INHIBIT_BIT];
            end
            if (setup_rd) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence ramp_from_zero;
        (ss_level_q == '0) ##1 (ss_level_q <= 8'h01);
    endsequence

    sequence recharge_done;
        (state_q == ST_RECHARGE) && vcc_high && !vcc_reset;
    endsequence

    chk_qual_fault_entry: assert property (
        qual_exp && !cs_hit && !vcc_low && !vcc_reset |=> state_q == ST_FAULT ##1 !drive_enable)
        else $error("expired qualification did not stop drive");

    chk_timer_clears: assert property (
        !err_s |=> qual_cnt_q == '0)
        else $error("qualification timer not cleared");

    chk_timer_counts: assert property (
        in_run && err_s && !qual_exp && !vcc_reset && !cs_hit && !vcc_low
        |=> qual_cnt_q == $past(qual_cnt_q) + 1'b1)
        else $error("qualification timer not counting");

    chk_latchoff_entry: assert property (
        state_q == ST_FAULT && vcc_low && !vcc_reset |=> state_q == ST_LATCHOFF && low_power)
        else $error("latch-off not entered");

    chk_uvlo_direct: assert property (
        in_run && vcc_low && !cs_hit && !vcc_reset |=> state_q == ST_LATCHOFF)
        else $error("undervoltage did not force latch-off");

    chk_recharge_source: assert property (
        state_q == ST_LATCHOFF && vcc_latchoff && !vcc_reset |=> startup_source_en [*1])
        else $error("startup source not enabled at latch-off level");

    chk_div_two: assert property (
        recharge_done |=> (state_q == ST_RUN) == $past(div_q))
        else $error("divide-by-two restart wrong");

    chk_cs_offtime: assert property (
        in_run && cs_s && sw_on_s && !vcc_reset |=> state_q != ST_CSLATCH)
        else $error("sense latch taken during on time");

    chk_cs_held: assert property (
        state_q == ST_CSLATCH && !vcc_reset |=> state_q == ST_CSLATCH && !drive_enable)
        else $error("sense latch released early");

    chk_cs_pfc_open: assert property (
        state_q == ST_CSLATCH |-> !front_end_supply_switch)
        else $error("supply switch closed while sense-latched");

    chk_ramp_restart: assert property (
        ss_start |=> ramp_from_zero)
        else $error("soft-start did not restart from zero");

    chk_pfc_close: assert property (
        in_run && err_fall && !qual_exp && !cs_hit && state_d == ST_RUN
        |=> front_end_supply_switch)
        else $error("supply switch not closed after flag drop");

    chk_startup_drive: assert property (
        state_q == ST_CHARGE && vcc_high && !vcc_reset && !cs_hit && !inhibit_q
        |=> state_q == ST_RUN && drive_enable && !startup_source_en)
        else $error("startup did not hand over to drive");

    chk_ramp_rises: assert property (
        in_run && !ss_start && ss_tick && ss_level_q != LEVEL_MAX
        |=> ss_level_q == $past(ss_level_q) + 1'b1)
        else $error("soft-start ramp did not step up");

    chk_ramp_holds: assert property (
        in_run && !ss_start && ss_level_q == LEVEL_MAX |=> ss_level_q == LEVEL_MAX)
        else $error("soft-start ramp left its maximum");

    chk_skip_ramp: assert property (
        in_run && skip_exit |=> ss_level_q == '0)
        else $error("leaving skip did not rerun the ramp");

    chk_restart_run: assert property (
        restart && !vcc_reset && !cs_hit && !inhibit_q |=> state_q == ST_RUN && drive_enable)
        else $error("restart did not resume switching");

    chk_expiry_opens: assert property (
        qual_exp |=> !front_end_supply_switch)
        else $error("supply switch closed after expiry");

    chk_fault_open: assert property (
        state_q == ST_FAULT |-> !front_end_supply_switch)
        else $error("supply switch closed during fault");

    chk_vcc_restart: assert property (
        vcc_reset |=> state_q == ST_CHARGE && !div_q)
        else $error("Vcc reset level did not restart sequencing");

    chk_latchoff_quiet: assert property (
        state_q == ST_LATCHOFF |-> low_power && !drive_enable)
        else $error("latch-off not quiet");

    chk_fault_no_drive: assert property (
        state_q == ST_FAULT |-> !drive_enable)
        else $error("drive active during fault");

    chk_latchoff_wait: assert property (
        state_q == ST_LATCHOFF && !vcc_latchoff && !vcc_reset |=> state_q == ST_LATCHOFF)
        else $error("latch-off left before latch-off level");
endmodule
`default_nettype wire

/* rtl/smps_supervisor_pkg.sv */
// Constants and state encoding for the switching supply fault and startup supervisor
//
// Contract
// - Error flag rising starts a 125 ms qualification timer.
// - Flag still high at timer expiry is a fault; gate drive stops.
// - Vcc below low undervoltage threshold enters reduced-consumption latch-off, no pulses.
// - In latch-off, at latch-off level enable startup source until high threshold.
// - Divide-by-two: restart only on every second completed startup charge.
// - Restart with error flag low returns to normal switching.
// - Flag dropping before expiry clears timer, no fault declared.
// - Expiry in skip mode opens front-end supply switch until normal operation resumes.
// - Undervoltage enters latch-off directly, without timer or error flag.
// - Sense overvoltage comparator sampled only during switch off time.
// - Sense pin above latch level stops drive; latched until Vcc below reset.
// - While sense-latched, front-end supply switch stays open.
// - Power-up: source charges Vcc; at stop threshold source off, drive on.
// - Peak current at clamp asserts error flag, arming the timer.
// - Flag dropping before timeout closes front-end supply switch.
// - Flag high at end of startup interval: skip, switch kept open.
// - At startup stop threshold a soft-start ramp raises the current limit.
// - Full soft-start ramp reruns on every restart attempt.
// - Soft-start also after overcurrent event and on leaving skip blanking.
package smps_supervisor_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned QUAL_TIME_MS = 125;
    localparam int unsigned QUAL_CYCLES = QUAL_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned SS_TIME_US = 2500;
    localparam int unsigned SS_CYCLES = SS_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned QUAL_W = 23;
    localparam int unsigned SS_W = 17;
    localparam int unsigned LEVEL_W = 8;
    localparam logic [LEVEL_W-1:0] LEVEL_MAX = 8'hFF;
    localparam int unsigned LEVEL_STEPS = 256;

    // ------------------------------------------------------------
    // Comparator input vector positions
    // ------------------------------------------------------------
    localparam int unsigned CMP_N = 8;
    localparam int unsigned CMP_VCC_HIGH = 0;
    localparam int unsigned CMP_VCC_LOW = 1;
    localparam int unsigned CMP_VCC_LATCHOFF = 2;
    localparam int unsigned CMP_VCC_RESET = 3;
    localparam int unsigned CMP_CLAMP = 4;
    localparam int unsigned CMP_CS_LATCH = 5;
    localparam int unsigned CMP_SKIP = 6;
    localparam int unsigned CMP_SWITCH_ON = 7;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam int unsigned CTRL_INHIBIT_BIT = 0;
    localparam logic CTRL_INHIBIT_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_CHARGE = 3'b000,
        ST_RUN = 3'b001,
        ST_FAULT = 3'b010,
        ST_LATCHOFF = 3'b011,
        ST_RECHARGE = 3'b100,
        ST_CSLATCH = 3'b101
    } sup_state_e;
endpackage

/* tb/supply_model.sv */
// Behavioural power stage and Vcc comparators facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
    parameter int HIGH_MV = 12600,
    parameter int LOW_MV = 7700,
    parameter int LATCHOFF_MV = 5600,
    parameter int RESET_MV = 4000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stimulus from the bench
    input var int vcc_mv,
    input wire logic clamp_req,
    input wire logic cs_req,
    input wire logic cs_on_req,
    input wire logic skip_req,
    // Supervisor outputs
    input wire logic drive_enable,
    // Comparator outputs
    output logic vcc_above_high,
    output logic vcc_below_low,
    output logic vcc_below_latchoff,
    output logic vcc_below_reset,
    output logic peak_clamp,
    output logic cs_above_latch,
    output logic skip_request,
    output logic switch_on
);
    logic [1:0] phase_q;

    // Comparators follow the rail level; switch pulses only while drive runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= drive_enable ? phase_q + 2'h1 : 2'h0;
        end
    end
    assign vcc_above_high = (vcc_mv > HIGH_MV);
    assign vcc_below_low = (vcc_mv < LOW_MV);
    assign vcc_below_latchoff = (vcc_mv <= LATCHOFF_MV);
    assign vcc_below_reset = (vcc_mv < RESET_MV);
    assign peak_clamp = clamp_req & drive_enable;
    // The on-time request only lifts the sense pin while the switch conducts
    assign cs_above_latch = cs_req | (cs_on_req & switch_on);
    assign skip_request = skip_req;
    assign switch_on = drive_enable & phase_q[1];
endmodule
`default_nettype wire

/* tb/smps_fault_startup_supervisor_tb_top.sv */
// Self-checking bench for the fault and startup supervisor
`timescale 1ns/1ps
`default_nettype none
module smps_fault_startup_supervisor_tb_top;
    import smps_supervisor_pkg::*;
    localparam int unsigned QC = 64;
    localparam int unsigned SC = 512;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e;
    logic ahi, blo, blat, brst, clampo, cso, skipo, swon;
    logic drive_enable, startup_source_en, low_power, error_flag, front_end_supply_switch;
    logic [LEVEL_W-1:0] current_limit_level;
    int vcc = 0;
    logic clamp = 1'b0, cs = 1'b0, skip = 1'b0, cs_on = 1'b0;
    int fails = 0, checks = 0;

    always #12.5 pclk = ~pclk;

    smps_fault_startup_supervisor #(.QUAL_COUNT(QC), .SS_COUNT(SC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vcc_above_high(ahi), .vcc_below_low(blo), .vcc_below_latchoff(blat),
        .vcc_below_reset(brst), .peak_clamp(clampo), .cs_above_latch(cso),
        .skip_request(skipo), .switch_on(swon), .drive_enable(drive_enable),
        .startup_source_en(startup_source_en), .low_power(low_power),
        .error_flag(error_flag), .front_end_supply_switch(front_end_supply_switch),
        .current_limit_level(current_limit_level));

    supply_model model (
        .pclk(pclk), .presetn(presetn), .vcc_mv(vcc), .clamp_req(clamp), .cs_req(cs),
        .skip_req(skip), .cs_on_req(cs_on), .drive_enable(drive_enable), .vcc_above_high(ahi),
        .vcc_below_low(blo), .vcc_below_latchoff(blat), .vcc_below_reset(brst),
        .peak_clamp(clampo), .cs_above_latch(cso), .skip_request(skipo), .switch_on(swon));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Outputs settle one step after the edge so sampling never races the design
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic state_is(input logic [2:0] s);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk({29'h0, r[2:0]}, {29'h0, s});
    endtask

    task automatic set_vcc(input int mv);
        @(posedge pclk);
        vcc <= mv;
        tick(6);
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        chk({31'h0, startup_source_en}, 32'h1); // source on
        chk({31'h0, drive_enable}, 32'h0); // no drive
        chk({24'h0, current_limit_level}, 32'h0); // ramp idle
        state_is(3'h0); // charging
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        set_vcc(13000);
        chk({30'h0, drive_enable, startup_source_en}, 32'h2); // drive on, source off
        state_is(3'h1); // running
        chk({31'h0, front_end_supply_switch}, 32'h0); // open before qualification
        tick(SC + 20);
        chk({24'h0, current_limit_level}, {24'h0, LEVEL_MAX}); // ramp complete
        // Transient: flag drops just short of expiry
        @(posedge pclk) clamp <= 1'b1;
        tick(QC - 8);
        chk({31'h0, error_flag}, 32'h1); // flag raised
        @(posedge pclk) clamp <= 1'b0;
        tick(6);
        chk({31'h0, drive_enable}, 32'h1); // no fault declared
        chk({31'h0, front_end_supply_switch}, 32'h1); // switch closes
        apb(1'b1, CTRL_OFF, 32'h1);
        tick(2);
        chk({31'h0, drive_enable}, 32'h0);
        apb(1'b1, CTRL_OFF, 32'h0);
        tick(2);
        chk({31'h0, drive_enable}, 32'h1);
        // Leaving skip blanking reruns the ramp
        @(posedge pclk) skip <= 1'b1;
        tick(6);
        @(posedge pclk) skip <= 1'b0;
        tick(6);
        chk({31'h0, current_limit_level < 8'h10}, 32'h1); // ramp restarts
        tick(SC + 20);
        // Genuine fault while skipping
        @(posedge pclk) begin
            skip <= 1'b1;
            clamp <= 1'b1;
        end
        tick(QC + 10);
        chk({30'h0, drive_enable, front_end_supply_switch}, 32'h0); // stop
        state_is(3'h2); // fault
        @(posedge pclk) begin
            skip <= 1'b0;
            clamp <= 1'b0;
        end
        set_vcc(7000);
        state_is(3'h3); // latch-off
        chk({30'h0, low_power, drive_enable}, 32'h2); // reduced, no pulses
        set_vcc(5000);
        state_is(3'h4); // recharge
        chk({31'h0, startup_source_en}, 32'h1); // source on
        set_vcc(13000);
        state_is(3'h2); // first charge skipped
        chk({31'h0, r[5]}, 32'h1); // divider set
        chk({31'h0, drive_enable}, 32'h0); // no restart yet
        set_vcc(7000);
        set_vcc(5000);
        set_vcc(13000);
        chk({31'h0, drive_enable}, 32'h1); // restart
        chk({31'h0, current_limit_level < 8'h10}, 32'h1); // full ramp again
        state_is(3'h1); // running
        chk({31'h0, r[5]}, 32'h0); // divider back
        tick(SC + 20);
        set_vcc(7000);
        state_is(3'h3); // direct latch-off
        set_vcc(3000);
        state_is(3'h0);
        set_vcc(13000);
        // Sense pin high only during on time must be ignored
        @(posedge pclk) cs_on <= 1'b1;
        tick(12);
        state_is(3'h1); // on-time excursion ignored
        @(posedge pclk) cs_on <= 1'b0;
        // Close the supply switch so that the sense trip has something to open
        @(posedge pclk) clamp <= 1'b1;
        tick(8);
        @(posedge pclk) clamp <= 1'b0;
        tick(6);
        chk({31'h0, front_end_supply_switch}, 32'h1); // closed before trip
        // Sense-pin latch
        @(posedge pclk) cs <= 1'b1;
        tick(10);
        chk({30'h0, drive_enable, front_end_supply_switch}, 32'h0); // latched
        state_is(3'h5); // latched
        @(posedge pclk) cs <= 1'b0;
        set_vcc(5000);
        state_is(3'h5); // holds above reset level
        set_vcc(3000);
        state_is(3'h0); // released by Vcc reset
        close_out();
    end
endmodule
`default_nettype wire
